// [chgim_pkg.sv]
// Constants shared by the charger interrupt mask block.
// Assumes a single 40 MHz clock and byte-wide register access.
package chgim_pkg;

	localparam logic [7:0] CHGIM_FLAG_A_OFS = 8'h25;
	localparam logic [7:0] CHGIM_FLAG_B_OFS = 8'h26;
	localparam logic [7:0] CHGIM_MASK_A_OFS = 8'h28;
	localparam logic [7:0] CHGIM_MASK_B_OFS = 8'h29;
	localparam logic [7:0] CHGIM_MASK_A_RST = 8'h00;
	localparam logic [7:0] CHGIM_MASK_B_RST = 8'h00;
	localparam logic [7:0] CHGIM_FLAG_RST = 8'h00;
	// Writable bit positions of each mask byte; the rest are reserved.
	localparam logic [7:0] CHGIM_A_IMPL = 8'heb;
	localparam logic [7:0] CHGIM_B_IMPL = 8'h9b;

	localparam int CHGIM_A_ADC = 7;
	localparam int CHGIM_A_ICUR = 6;
	localparam int CHGIM_A_VIN = 5;
	localparam int CHGIM_A_WDOG = 3;
	localparam int CHGIM_A_CVTMR = 1;
	localparam int CHGIM_A_CHG = 0;
	localparam int CHGIM_B_PGOOD = 7;
	localparam int CHGIM_B_THERM = 4;
	localparam int CHGIM_B_REV = 3;
	localparam int CHGIM_B_FLOCK = 1;
	localparam int CHGIM_B_SOLAR = 0;

	localparam int CHGIM_CLK_PERIOD_PS = 25000;
	localparam int CHGIM_INT_PULSE_NS = 10000;
	localparam int CHGIM_INT_PULSE_CYC =
		(CHGIM_INT_PULSE_NS * 1000 + CHGIM_CLK_PERIOD_PS - 1) /
		CHGIM_CLK_PERIOD_PS;
	localparam int CHGIM_CNT_W = 9;

endpackage

// [chgim_evdet.sv]
// Change or rising-edge detector for one event source.
// Assumes the source is already in the clock domain of this block.
`timescale 1ns/1ps
`default_nettype none
module chgim_evdet #(
	parameter int W = 1,
	parameter bit RISE = 1'b0
) (
	input wire logic clock, // Block clock.
	input wire logic rst_n, // Synchronised reset, active low.
	input wire logic [W-1:0] sig, // Watched status value.
	output logic ev // One-cycle event pulse.
);
	logic [W-1:0] prev_q;
	logic [W-1:0] prev_d;
	logic armed_q;
	logic armed_d;

	always_comb begin
		prev_d = sig;
		armed_d = 1'b1;
		// The first sample after reset only primes the history.
		if (RISE) begin
			ev = armed_q && (prev_q == '0) && (sig != '0);
		end else begin
			ev = armed_q && (prev_q != sig);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= '0;
			armed_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			armed_q <= armed_d;
		end
	end
endmodule // chgim_evdet
`default_nettype wire

// [chgim_top.sv]
// Charger event flags, two interrupt mask bytes and the interrupt pulse.
// Assumes a byte register port from the serial front end on the same clock,
// and an external pull-up on the open-drain interrupt line.
//
// Function
// - Mask A bit 7 gates one-shot ADC completion.
// - Mask A bit 6 gates input current regulation.
// - Mask A bit 5 gates input voltage regulation.
// - Mask A bit 3 gates watchdog expiry.
// - Mask A bit 1 gates CV timer rise.
// - Mask A bit 0 gates charge state change.
// - Mask B bit 7 gates power-good toggle.
// - Mask B bit 4 gates thermistor zone change.
// - Mask B bit 3 gates reverse-mode toggle.
// - Mask B bit 1 gates frequency lock change.
// - Mask B bit 0 gates solar tracking rise.
// - Mask A at 0x28, resets to zero.
// - Mask B at 0x29, cleared by software reset.
// - Flags clear when software reads them.
`timescale 1ns/1ps
`default_nettype none
module chgim_top
	import chgim_pkg::*;
(
	input wire logic clock, // 40 MHz block clock.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic [7:0] reg_addr, // Register address.
	input wire logic reg_wr, // Write strobe, one cycle.
	input wire logic [7:0] reg_wdata, // Write data.
	input wire logic reg_rd, // Read strobe, one cycle.
	output logic [7:0] reg_rdata_q, // Read data, valid after reg_rd.
	input wire logic reg_reset_req, // Software register reset pulse.
	input wire logic adc_done, // ADC conversion complete pulse.
	input wire logic adc_one_shot, // ADC in one-shot mode.
	input wire logic in_cur_reg, // In input current regulation.
	input wire logic in_volt_reg, // In input voltage regulation.
	input wire logic wdog_expired, // Serial watchdog expired.
	input wire logic cv_tmr_expired, // CV timer expired.
	input wire logic [2:0] charge_state, // Charge cycle state.
	input wire logic power_good_indication, // Input power good.
	input wire logic [2:0] thermistor_zone_state, // Thermistor zone.
	input wire logic reverse_mode, // Reverse mode active.
	input wire logic freq_lock_pin, // Sync pin status, asynchronous.
	input wire logic [1:0] solar_tracking_state, // Solar tracking state.
	output logic int_pin_o_q, // Interrupt pin drive level, always 0.
	output logic int_pin_oe_q // Interrupt pin enable, high pulls low.
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [1:0] flock_sync_q;
	logic [15:0] ev;
	logic [7:0] mask_a_q, mask_a_d, mask_b_q, mask_b_d;
	logic [7:0] flag_a_q, flag_a_d, flag_b_q, flag_b_d;
	logic [7:0] rdata_d;
	logic [CHGIM_CNT_W-1:0] cnt_q, cnt_d;
	logic [15:0] fire;
	logic int_oe_d;

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchroniser.

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flock_sync_q <= 2'h0;
		end else begin
			flock_sync_q <= {flock_sync_q[0], freq_lock_pin};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event detection, low byte follows mask A and high byte mask B.

	assign ev[4] = 1'b0;
	assign ev[2] = 1'b0;
	assign ev[14] = 1'b0;
	assign ev[13] = 1'b0;
	assign ev[10] = 1'b0;

	chgim_evdet #(.W(1), .RISE(1'b1)) u_adc (
		.clock(clock), .rst_n(rst_n), .sig(adc_done & adc_one_shot),
		.ev(ev[CHGIM_A_ADC]));
	chgim_evdet #(.W(1), .RISE(1'b1)) u_icur (
		.clock(clock), .rst_n(rst_n), .sig(in_cur_reg),
		.ev(ev[CHGIM_A_ICUR]));
	chgim_evdet #(.W(1), .RISE(1'b1)) u_vin (
		.clock(clock), .rst_n(rst_n), .sig(in_volt_reg),
		.ev(ev[CHGIM_A_VIN]));
	chgim_evdet #(.W(1), .RISE(1'b1)) u_wdog (
		.clock(clock), .rst_n(rst_n), .sig(wdog_expired),
		.ev(ev[CHGIM_A_WDOG]));
	chgim_evdet #(.W(1), .RISE(1'b1)) u_cvtmr (
		.clock(clock), .rst_n(rst_n), .sig(cv_tmr_expired),
		.ev(ev[CHGIM_A_CVTMR]));
	chgim_evdet #(.W(3), .RISE(1'b0)) u_chg (
		.clock(clock), .rst_n(rst_n), .sig(charge_state),
		.ev(ev[CHGIM_A_CHG]));
	chgim_evdet #(.W(1), .RISE(1'b0)) u_pgood (
		.clock(clock), .rst_n(rst_n), .sig(power_good_indication),
		.ev(ev[8 + CHGIM_B_PGOOD]));
	chgim_evdet #(.W(3), .RISE(1'b0)) u_therm (
		.clock(clock), .rst_n(rst_n), .sig(thermistor_zone_state),
		.ev(ev[8 + CHGIM_B_THERM]));
	chgim_evdet #(.W(1), .RISE(1'b0)) u_rev (
		.clock(clock), .rst_n(rst_n), .sig(reverse_mode),
		.ev(ev[8 + CHGIM_B_REV]));
	chgim_evdet #(.W(1), .RISE(1'b0)) u_flock (
		.clock(clock), .rst_n(rst_n), .sig(flock_sync_q[1]),
		.ev(ev[8 + CHGIM_B_FLOCK]));
	chgim_evdet #(.W(2), .RISE(1'b1)) u_solar (
		.clock(clock), .rst_n(rst_n), .sig(solar_tracking_state),
		.ev(ev[8 + CHGIM_B_SOLAR]));

	////////////////////////////////////////////////////////////////////////
	// Registers: masks, flags and read data.

	always_comb begin
		mask_a_d = mask_a_q;
		mask_b_d = mask_b_q;
		flag_a_d = flag_a_q;
		flag_b_d = flag_b_q;
		rdata_d = reg_rdata_q;
		if (reg_wr && reg_addr == CHGIM_MASK_A_OFS) begin
			mask_a_d = reg_wdata & CHGIM_A_IMPL;
		end
		if (reg_wr && reg_addr == CHGIM_MASK_B_OFS) begin
			mask_b_d = reg_wdata & CHGIM_B_IMPL;
		end
		if (reg_reset_req) begin
			mask_a_d = CHGIM_MASK_A_RST;
			mask_b_d = CHGIM_MASK_B_RST;
		end
		if (reg_rd) begin
			unique case (reg_addr)
				CHGIM_FLAG_A_OFS: begin
					rdata_d = flag_a_q;
					flag_a_d = CHGIM_FLAG_RST;
				end
				CHGIM_FLAG_B_OFS: begin
					rdata_d = flag_b_q;
					flag_b_d = CHGIM_FLAG_RST;
				end
				CHGIM_MASK_A_OFS: rdata_d = mask_a_q;
				CHGIM_MASK_B_OFS: rdata_d = mask_b_q;
				default: rdata_d = 8'h00;
			endcase
		end
		// A new event wins over the clear of a read in the same cycle.
		flag_a_d = flag_a_d | ev[7:0];
		flag_b_d = flag_b_d | ev[15:8];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask_a_q <= CHGIM_MASK_A_RST;
			mask_b_q <= CHGIM_MASK_B_RST;
			flag_a_q <= CHGIM_FLAG_RST;
			flag_b_q <= CHGIM_FLAG_RST;
			reg_rdata_q <= 8'h00;
		end else begin
			mask_a_q <= mask_a_d;
			mask_b_q <= mask_b_d;
			flag_a_q <= flag_a_d;
			flag_b_q <= flag_b_d;
			reg_rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt pulse: an unmasked event (re)starts a fixed-length pulse.

	always_comb begin
		fire = ev & ~{mask_b_q, mask_a_q};
		cnt_d = cnt_q;
		if (|fire) begin
			cnt_d = CHGIM_CNT_W'(CHGIM_INT_PULSE_CYC);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - CHGIM_CNT_W'(1);
		end
		int_oe_d = (cnt_d != '0);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			int_pin_oe_q <= 1'b0;
			int_pin_o_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			int_pin_oe_q <= int_oe_d;
			int_pin_o_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	adc_gate_a: assert property (ev == 16'h0080 && mask_a_q[7] &&
		cnt_q == '0 |=> !int_pin_oe_q)
		else $error("masked ADC event drove interrupt");
	icur_fire_a: assert property (ev[6] && !mask_a_q[6] |=>
		int_pin_oe_q && cnt_q == CHGIM_CNT_W'(CHGIM_INT_PULSE_CYC))
		else $error("input current event gave no pulse");
	pgood_gate_a: assert property (ev[15] && !mask_b_q[7] |=>
		int_pin_oe_q)
		else $error("power good toggle gave no pulse");
	mask_rsv_a: assert property ((mask_a_q & ~CHGIM_A_IMPL) == 8'h00 &&
		(mask_b_q & ~CHGIM_B_IMPL) == 8'h00)
		else $error("reserved mask bit set");
	sw_reset_a: assert property (reg_reset_req |=>
		mask_a_q == 8'h00 && mask_b_q == 8'h00)
		else $error("software reset left a mask bit set");
	mask_write_a: assert property (reg_wr && !reg_reset_req &&
		reg_addr == CHGIM_MASK_A_OFS |=> mask_a_q == ($past(reg_wdata) &
		CHGIM_A_IMPL))
		else $error("mask A write not stored");
	flag_set_a: assert property (|ev |=>
		({flag_b_q, flag_a_q} & $past(ev)) == $past(ev))
		else $error("event did not set its flag");
	flag_clear_a: assert property (reg_rd && reg_addr == CHGIM_FLAG_A_OFS
		&& ev[7:0] == 8'h00 |=> flag_a_q == 8'h00 &&
		reg_rdata_q == $past(flag_a_q))
		else $error("flag read did not clear");
	pulse_len_a: assert property (int_pin_oe_q && fire == '0 |=>
		cnt_q == $past(cnt_q) - CHGIM_CNT_W'(1))
		else $error("interrupt pulse count wrong");
endmodule // chgim_top
`default_nettype wire

// [chgim_host.sv]
// Host end of the open-drain interrupt line with its pull-up.
// Assumes the device drives the line low only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module chgim_host (
	input wire logic clock, // Block clock.
	input wire logic rst_b, // Reset, active low.
	input wire logic int_o, // Device drive level.
	input wire logic int_oe, // Device drive enable.
	output logic int_line, // Resolved line level.
	output int pulse_cnt, // Pulses seen.
	output int low_len // Low cycles of the last pulse.
);
	int run;
	logic last;
	// The pull-up holds the line high whenever the device lets go.
	assign int_line = int_oe ? int_o : 1'b1;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			run <= 0;
			last <= 1'b1;
			pulse_cnt <= 0;
			low_len <= 0;
		end else begin
			last <= int_line;
			run <= int_line ? 0 : run + 1;
			if (!int_line && last) pulse_cnt <= pulse_cnt + 1;
			if (int_line && !last) low_len <= run;
		end
	end
endmodule // chgim_host
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the charger interrupt mask block.
// Assumes the host model resolves the interrupt line.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import chgim_pkg::*;
	logic clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q, q;
	logic reg_reset_req = 1'b0, adc_done = 1'b0, adc_one_shot = 1'b1;
	logic in_cur_reg = 1'b0, in_volt_reg = 1'b0, wdog_expired = 1'b0;
	logic cv_tmr_expired = 1'b0, power_good_indication = 1'b0;
	logic reverse_mode = 1'b0, freq_lock_pin = 1'b0;
	logic [2:0] charge_state = 3'h0, thermistor_zone_state = 3'h0;
	logic [1:0] solar_tracking_state = 2'h0;
	logic int_pin_o_q, int_pin_oe_q, int_line;
	int pulse_cnt, low_len, error_cnt = 0, num_checks = 0, cyc = 0;
	int bitpos [11] = '{7, 6, 5, 3, 1, 0, 7, 4, 3, 1, 0};
	always #12.5 clock = !clock;
	chgim_top uut (.clock, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata_q, .reg_reset_req, .adc_done, .adc_one_shot, .in_cur_reg,
		.in_volt_reg, .wdog_expired, .cv_tmr_expired, .charge_state,
		.power_good_indication, .thermistor_zone_state, .reverse_mode,
		.freq_lock_pin, .solar_tracking_state, .int_pin_o_q, .int_pin_oe_q);
	chgim_host host (.clock, .rst_b, .int_o(int_pin_o_q),
		.int_oe(int_pin_oe_q), .int_line, .pulse_cnt, .low_len);
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		@(negedge clock);
		q = reg_rdata_q;
	endtask
	task automatic fire(input int i);
		case (i)
			0: adc_done = 1'b1;
			1: in_cur_reg = 1'b1;
			2: in_volt_reg = 1'b1;
			3: wdog_expired = 1'b1;
			4: cv_tmr_expired = 1'b1;
			5: charge_state = charge_state + 3'h1;
			6: power_good_indication = !power_good_indication;
			7: thermistor_zone_state = thermistor_zone_state + 3'h1;
			8: reverse_mode = !reverse_mode;
			9: freq_lock_pin = !freq_lock_pin;
			default: solar_tracking_state = 2'h1;
		endcase
		@(negedge clock);
		{adc_done, in_cur_reg, in_volt_reg, wdog_expired} = 4'h0;
		cv_tmr_expired = 1'b0;
		solar_tracking_state = 2'h0;
		repeat (6) @(negedge clock);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic test_reset;
		for (int i = 0; i < 4; i++) begin
			bus(8'h25 + i[7:0] + (i > 1 ? 8'h01 : 8'h00), 1'b0, 8'h00);
			check("reset value", q, 8'h00);
		end
		check("idle line", int_line, 1'b1);
	endtask
	task automatic test_reserved;
		bus(CHGIM_MASK_A_OFS, 1'b1, 8'hff);
		bus(CHGIM_MASK_A_OFS, 1'b0, 8'h00);
		check("mask a", q, 8'heb);
		bus(CHGIM_MASK_B_OFS, 1'b1, 8'hff);
		bus(CHGIM_MASK_B_OFS, 1'b0, 8'h00);
		check("mask b", q, 8'h9b);
		bus(8'h30, 1'b0, 8'h00);
		check("unmapped", q, 8'h00);
	endtask
	task automatic test_swreset;
		reg_reset_req = 1'b1;
		bus(CHGIM_MASK_A_OFS, 1'b1, 8'hff);
		reg_reset_req = 1'b0;
		bus(CHGIM_MASK_A_OFS, 1'b0, 8'h00);
		check("swreset a", q, 8'h00);
		bus(CHGIM_MASK_B_OFS, 1'b0, 8'h00);
		check("swreset b", q, 8'h00);
	endtask
	task automatic test_events;
		logic [7:0] a, m;
		int n;
		for (int i = 0; i < 11; i++) begin
			a = (i < 6) ? CHGIM_FLAG_A_OFS : CHGIM_FLAG_B_OFS;
			m = 8'h01 << bitpos[i];
			bus(a + 8'h03, 1'b1, m);
			n = pulse_cnt;
			fire(i);
			check("masked pulse", pulse_cnt, n);
			bus(a, 1'b0, 8'h00);
			check("masked flag", q, m);
			bus(a, 1'b0, 8'h00);
			check("flag cleared", q, 8'h00);
			bus(a + 8'h03, 1'b1, 8'h00);
			fire(i);
			check("line low", int_line, 1'b0);
			check("pulse count", pulse_cnt, n + 1);
			bus(a, 1'b0, 8'h00);
			check("flag", q, m);
			repeat (CHGIM_INT_PULSE_CYC + 10) @(negedge clock);
			check("pulse length", low_len, CHGIM_INT_PULSE_CYC);
		end
	endtask
	task automatic test_adc_mode;
		int n;
		adc_one_shot = 1'b0;
		n = pulse_cnt;
		fire(0);
		check("adc continuous pulse", pulse_cnt, n);
		bus(CHGIM_FLAG_A_OFS, 1'b0, 8'h00);
		check("adc continuous flag", q, 8'h00);
		adc_one_shot = 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////
	task end_sim;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim;
		end
	end
	initial begin
		repeat (8) @(negedge clock);
		rst_b = 1'b1;
		repeat (3) @(negedge clock);
		test_reset;
		test_reserved;
		test_swreset;
		test_events;
		test_adc_mode;
		end_sim;
	end
endmodule // testbench
`default_nettype wire
